// File: logic/fsc_pkg.sv
// Function
// - An imprecise data bus error stays pending while the running priority beats the handler.
// - A precise fault arriving before the imprecise handler starts leaves both flags set.
// - A data bus error tied to the stacked return address sets the precise flag.
// - Every precise data bus error latches its access address into bus_fault_address_reg.
// - A prefetch bus error sets fetch_bus_err_flag only when that instruction is issued.
// - Fetch and imprecise errors never update bus_fault_address_reg.
// - mem_fault_addr_valid reads 1 only while mem_fault_address_reg holds a fault address.
// - Status bits 6:5 are read-only zero and software preserves them.
// - All flags reset to 0 and each clears when software writes 1 to it.
package fsc_pkg;
  // Register byte offsets within the slave window
  localparam logic [7:0]  ADDR_STATUS   = 8'h00;
  localparam logic [7:0]  ADDR_BUS_ADDR = 8'h04;
  localparam logic [7:0]  ADDR_MEM_ADDR = 8'h08;
  localparam logic [7:0]  ADDR_PRIO     = 8'h0c;
  localparam logic [7:0]  ADDR_PEND     = 8'h10;
  // Status bit positions
  localparam int unsigned BIT_STK_VIOL  = 4;
  localparam int unsigned BIT_MEM_VALID = 7;
  localparam int unsigned BIT_FETCH     = 8;
  localparam int unsigned BIT_PRECISE   = 9;
  localparam int unsigned BIT_IMPRECISE_BUS_ERR_FLAG     = 10;
  // Pending register bit positions
  localparam int unsigned BIT_PEND      = 0;
  localparam int unsigned BIT_ACTIVE    = 1;
  // Widths and reset values
  localparam int unsigned PRIO_W        = 8;
  localparam logic [7:0]  PRIO_RESET    = 8'h00;
  localparam logic [31:0] ADDR_RESET    = 32'h0000_0000;
  localparam logic [31:0] DATA_ZERO     = 32'h0000_0000;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic        HRESP_OKAY    = 1'h0;
  // Imprecise error tracking states
  typedef enum logic [1:0] {FSC_IDLE, FSC_PENDING, FSC_ACTIVE} fsc_pend_state_t;
endpackage

// File: logic/fsc_pend.sv
`timescale 1ns/1ps
// Holds an imprecise bus error until the core priority lets its handler run
module fsc_pend (
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  input  wire logic                     ce,
  input  wire logic                     err_evt,
  input  wire logic [fsc_pkg::PRIO_W-1:0] cur_prio,
  input  wire logic [fsc_pkg::PRIO_W-1:0] handler_prio,
  input  wire logic                     handler_entry,
  output logic                          pending,
  output logic                          activate
);
  typedef struct packed {
    fsc_pkg::fsc_pend_state_t state;
    logic                     pending;
    logic                     activate;
  } fsc_pend_st_t;

  fsc_pend_st_t st;
  fsc_pend_st_t next_st;

  // Lower number is higher priority; run only once every stronger context has returned
  always_comb
  begin
    next_st = st;
    unique case (st.state)
      fsc_pkg::FSC_IDLE:
        if (err_evt)
          next_st.state = fsc_pkg::FSC_PENDING;
      fsc_pkg::FSC_PENDING:
        if (cur_prio > handler_prio)
          next_st.state = fsc_pkg::FSC_ACTIVE;
      fsc_pkg::FSC_ACTIVE:
        if (handler_entry && !err_evt)
          next_st.state = fsc_pkg::FSC_IDLE;
        else if (handler_entry)
          next_st.state = fsc_pkg::FSC_PENDING;
      default:
        next_st.state = fsc_pkg::FSC_IDLE;
    endcase
    next_st.pending  = (next_st.state == fsc_pkg::FSC_PENDING);
    next_st.activate = (next_st.state == fsc_pkg::FSC_ACTIVE);
  end

  // State freezes while the clock enable is low
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      st <= '{fsc_pkg::FSC_IDLE, 1'b0, 1'b0};
    else if (ce)
      st <= next_st;
  end

  assign pending  = st.pending;
  assign activate = st.activate;

  pend_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && st.pending && (cur_prio <= handler_prio) |=> !st.activate)
    else $error("imprecise error activated under higher priority");
endmodule

// File: logic/fsc_top.sv
// The AHB-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
// Fault status capture with an AHB-Lite register slave
module fsc_top (
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  input  wire logic                       ce,
  input  wire logic                       hsel,
  input  wire logic [31:0]                haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic                       hready,
  input  wire logic [31:0]                hwdata,
  input  wire logic                       imprecise_err_evt,
  input  wire logic                       precise_err_evt,
  input  wire logic [31:0]                precise_addr,
  input  wire logic                       fetch_err_evt,
  input  wire logic                       fetch_issue,
  input  wire logic                       fetch_flush,
  input  wire logic                       mem_fault_evt,
  input  wire logic [31:0]                mem_fault_addr,
  input  wire logic                       stacking_viol_evt,
  input  wire logic [fsc_pkg::PRIO_W-1:0] cur_prio,
  input  wire logic                       handler_entry,
  output logic [31:0]                     hrdata,
  output logic                            hreadyout,
  output logic                            hresp,
  output logic                            imprecise_pending,
  output logic                            imprecise_activate
);
  typedef struct packed {
    logic [31:0]                hrdata;
    logic                       hreadyout;
    logic                       hresp;
    logic                       dp_write;
    logic [7:0]                 dp_addr;
    logic                       imprecise_bus_err_flag;
    logic                       precise;
    logic                       fetch;
    logic                       valid;
    logic                       stk;
    logic                       fetch_marked;
    logic [31:0]                bus_addr;
    logic [31:0]                mem_addr;
    logic [fsc_pkg::PRIO_W-1:0] handler_prio;
  } fsc_top_st_t;

  fsc_top_st_t st;
  fsc_top_st_t next_st;
  logic        addr_phase;
  logic        wr_status;
  logic [31:0] clr;
  logic        pend_q;
  logic        act_q;

  // A transfer is taken only when the bus is ready and the slave selected
  assign addr_phase = hsel && (htrans == fsc_pkg::HTRANS_NONSEQ) && hready;
  assign wr_status  = st.dp_write && (st.dp_addr == fsc_pkg::ADDR_STATUS);
  assign clr        = wr_status ? hwdata : fsc_pkg::DATA_ZERO;

  fsc_pend u_pend (
    .hclk          (hclk),
    .hresetn       (hresetn),
    .ce            (ce),
    .err_evt       (imprecise_err_evt),
    .cur_prio      (cur_prio),
    .handler_prio  (st.handler_prio),
    .handler_entry (handler_entry),
    .pending       (pend_q),
    .activate      (act_q)
  );

  // Register update; clears use write-one, sets are ORed in last so they win
  always_comb
  begin
    next_st = st;
    next_st.hreadyout = 1'b1;
    next_st.hresp     = fsc_pkg::HRESP_OKAY;
    next_st.dp_write  = addr_phase && hwrite;
    next_st.dp_addr   = haddr[7:0];
    next_st.imprecise_bus_err_flag   = (st.imprecise_bus_err_flag   & ~clr[fsc_pkg::BIT_IMPRECISE_BUS_ERR_FLAG])     | imprecise_err_evt;
    next_st.precise = (st.precise & ~clr[fsc_pkg::BIT_PRECISE])   | precise_err_evt;
    next_st.valid   = (st.valid   & ~clr[fsc_pkg::BIT_MEM_VALID]) | mem_fault_evt;
    next_st.stk     = (st.stk     & ~clr[fsc_pkg::BIT_STK_VIOL])  | stacking_viol_evt;
    // Prefetch error is only remembered; it counts once the instruction issues
    next_st.fetch   = (st.fetch   & ~clr[fsc_pkg::BIT_FETCH])
                      | (fetch_issue && (st.fetch_marked || fetch_err_evt));
    if (fetch_issue || fetch_flush)
      next_st.fetch_marked = 1'b0;
    else if (fetch_err_evt)
      next_st.fetch_marked = 1'b1;
    // Only the precise path owns the bus address; others leave it alone
    if (precise_err_evt)
      next_st.bus_addr = precise_addr;
    // Stacking violations carry no address, only access violations latch one
    if (mem_fault_evt)
      next_st.mem_addr = mem_fault_addr;
    if (st.dp_write && (st.dp_addr == fsc_pkg::ADDR_PRIO))
      next_st.handler_prio = hwdata[fsc_pkg::PRIO_W-1:0];
    // Read data reflect the state after this cycle's updates, except the pending register, which shows pend_q and act_q as they stand
    next_st.hrdata = fsc_pkg::DATA_ZERO;
    if (addr_phase && !hwrite)
    begin
      unique case (haddr[7:0])
        fsc_pkg::ADDR_STATUS:
        begin
          // Bits 6:5 and all others not assigned stay zero
          next_st.hrdata[fsc_pkg::BIT_IMPRECISE_BUS_ERR_FLAG]     = next_st.imprecise_bus_err_flag;
          next_st.hrdata[fsc_pkg::BIT_PRECISE]   = next_st.precise;
          next_st.hrdata[fsc_pkg::BIT_FETCH]     = next_st.fetch;
          next_st.hrdata[fsc_pkg::BIT_MEM_VALID] = next_st.valid;
          next_st.hrdata[fsc_pkg::BIT_STK_VIOL]  = next_st.stk;
        end
        fsc_pkg::ADDR_BUS_ADDR: next_st.hrdata = next_st.bus_addr;
        fsc_pkg::ADDR_MEM_ADDR: next_st.hrdata = next_st.mem_addr;
        fsc_pkg::ADDR_PRIO:     next_st.hrdata[fsc_pkg::PRIO_W-1:0] = next_st.handler_prio;
        fsc_pkg::ADDR_PEND:
        begin
          next_st.hrdata[fsc_pkg::BIT_PEND]   = pend_q;
          next_st.hrdata[fsc_pkg::BIT_ACTIVE] = act_q;
        end
        default:                next_st.hrdata = fsc_pkg::DATA_ZERO;
      endcase
    end
  end

  // Whole state frozen while clock enable is low, bus included
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st              <= '0;
      st.hreadyout    <= 1'b1;
      st.bus_addr     <= fsc_pkg::ADDR_RESET;
      st.mem_addr     <= fsc_pkg::ADDR_RESET;
      st.handler_prio <= fsc_pkg::PRIO_RESET;
    end
    else if (ce)
      st <= next_st;
  end

  assign hrdata             = st.hrdata;
  assign hreadyout          = st.hreadyout;
  assign hresp              = st.hresp;
  assign imprecise_pending  = pend_q;
  assign imprecise_activate = act_q;

  both_kept_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && st.imprecise_bus_err_flag && precise_err_evt && !wr_status |=> st.imprecise_bus_err_flag && st.precise)
    else $error("imprecise flag lost on precise fault");

  precise_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && precise_err_evt |=> st.precise)
    else $error("precise flag not set");

  precise_addr_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && precise_err_evt |=> st.bus_addr == $past(precise_addr))
    else $error("bus fault address not latched");

  fetch_discard_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && !st.fetch && !fetch_issue |=> !st.fetch)
    else $error("fetch flag set without issue");

  addr_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && !precise_err_evt |=> $stable(st.bus_addr))
    else $error("bus fault address changed without precise error");

  valid_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && mem_fault_evt |=> st.valid && st.mem_addr == $past(mem_fault_addr))
    else $error("memory fault address or valid wrong");

  reserved_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && addr_phase && !hwrite && haddr[7:0] == fsc_pkg::ADDR_STATUS |=> hrdata[6:5] == 2'h0)
    else $error("reserved status bits not zero");

  stk_noaddr_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && stacking_viol_evt && !mem_fault_evt |=> st.stk && $stable(st.mem_addr))
    else $error("stacking violation mishandled");

  w1c_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && wr_status && hwdata[fsc_pkg::BIT_PRECISE] && !precise_err_evt |=> !st.precise)
    else $error("precise flag not cleared by write one");

  set_wins_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && imprecise_err_evt && wr_status |=> st.imprecise_bus_err_flag)
    else $error("clear beat a same-cycle set");

  zero_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && st.stk && wr_status && !hwdata[fsc_pkg::BIT_STK_VIOL] |=> st.stk)
    else $error("writing zero cleared a flag");
endmodule

// File: test/fsc_core_model.sv
`timescale 1ns/1ps
// Core side: fault events as one-cycle pulses, execution priority as a level
module fsc_core_model (
  input  wire logic   hclk,
  output logic [7:0]  ev,
  output logic [31:0] addr,
  output logic [7:0]  prio
);
  // Idle values at time zero
  initial
  begin
    ev   = 8'h00;
    addr = 32'h0000_0000;
    prio = 8'h00;
  end
  // Address is inverted after the pulse so a stale value is never re-latched
  task automatic fire(input logic [7:0] e, input logic [31:0] a);
    @(posedge hclk);
    ev   <= e;
    addr <= a;
    @(posedge hclk);
    ev   <= 8'h00;
    addr <= ~a;
  endtask
  // Priority changes only right after an edge
  task automatic set_prio(input logic [7:0] p);
    @(posedge hclk);
    prio <= p;
  endtask
endmodule

// File: test/test_fault_status_capture.sv
`timescale 1ns/1ps
module test_fault_status_capture;
  localparam logic [31:0] S_IMP = 32'h1 << fsc_pkg::BIT_IMPRECISE_BUS_ERR_FLAG;
  localparam logic [31:0] S_PRE = 32'h1 << fsc_pkg::BIT_PRECISE;
  localparam logic [31:0] S_FET = 32'h1 << fsc_pkg::BIT_FETCH;
  localparam logic [31:0] S_MEM = 32'h1 << fsc_pkg::BIT_MEM_VALID;
  localparam logic [31:0] S_STK = 32'h1 << fsc_pkg::BIT_STK_VIOL;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic        imprecise_pending, imprecise_activate, imprecise_err_evt, precise_err_evt;
  logic        fetch_err_evt, fetch_issue, fetch_flush, mem_fault_evt, stacking_viol_evt;
  logic        handler_entry;
  logic [1:0]  htrans;
  logic [7:0]  ev, cur_prio;
  logic [31:0] haddr, hwdata, hrdata, ev_addr, rd;
  int          n_errors, num_checks;

  // Event pulses fan out from one vector of the core model
  assign {handler_entry, stacking_viol_evt, mem_fault_evt, fetch_flush, fetch_issue,
          fetch_err_evt, precise_err_evt, imprecise_err_evt} = ev;

  fsc_core_model i_core (.hclk, .ev, .addr(ev_addr), .prio(cur_prio));

  // Single slave, so its ready is the bus ready
  fsc_top i_dut (.hclk, .hresetn, .ce(1'b1), .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hready(hreadyout), .hwdata, .imprecise_err_evt, .precise_err_evt,
    .precise_addr(ev_addr), .fetch_err_evt, .fetch_issue, .fetch_flush, .mem_fault_evt,
    .mem_fault_addr(ev_addr), .stacking_viol_evt, .cur_prio, .handler_entry, .hrdata,
    .hreadyout, .hresp, .imprecise_pending, .imprecise_activate);

  // 50 MHz clock
  initial
  begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One AHB-Lite single word transfer; waits on ready, bounded by the watchdog
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= fsc_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    haddr  <= {24'h00_0000, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wr ? d : ~hwdata;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(what, exp, rd);
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Tests take under a hundred cycles; this limit is far above that
  initial
  begin
    #200000;
    n_errors++;
    conclude();
  end

  // Main sequence
  initial
  begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk("status", fsc_pkg::ADDR_STATUS, 32'h0000_0000);
    rd_chk("bus addr", fsc_pkg::ADDR_BUS_ADDR, fsc_pkg::ADDR_RESET);
    $display("test reset done");
    i_core.fire(8'h02, 32'h2000_0010);
    rd_chk("status", fsc_pkg::ADDR_STATUS, S_PRE);
    rd_chk("bus addr", fsc_pkg::ADDR_BUS_ADDR, 32'h2000_0010);
    i_core.fire(8'h01, 32'h3000_0000);
    i_core.fire(8'h04, 32'h3000_0004);
    i_core.fire(8'h08, 32'h3000_0008);
    rd_chk("status", fsc_pkg::ADDR_STATUS, S_IMP | S_PRE | S_FET);
    rd_chk("bus addr", fsc_pkg::ADDR_BUS_ADDR, 32'h2000_0010);
    $display("test bus errors done");
    bus(1'b1, fsc_pkg::ADDR_STATUS, 32'h0000_0000);
    rd_chk("status", fsc_pkg::ADDR_STATUS, S_IMP | S_PRE | S_FET);
    bus(1'b1, fsc_pkg::ADDR_STATUS, S_FET);
    i_core.fire(8'h04, 32'h3000_000c);
    i_core.fire(8'h10, 32'h3000_0010);
    i_core.fire(8'h08, 32'h3000_0014);
    rd_chk("status", fsc_pkg::ADDR_STATUS, S_IMP | S_PRE);
    bus(1'b1, fsc_pkg::ADDR_STATUS, 32'hffff_ffff);
    rd_chk("status", fsc_pkg::ADDR_STATUS, 32'h0000_0000);
    $display("test clearing done");
    i_core.fire(8'h20, 32'h4000_0abc);
    i_core.fire(8'h40, 32'h5555_0000);
    rd_chk("status", fsc_pkg::ADDR_STATUS, S_MEM | S_STK);
    rd_chk("mem addr", fsc_pkg::ADDR_MEM_ADDR, 32'h4000_0abc);
    bus(1'b1, fsc_pkg::ADDR_STATUS, S_MEM);
    rd_chk("status", fsc_pkg::ADDR_STATUS, S_STK);
    $display("test memory faults done");
    bus(1'b1, fsc_pkg::ADDR_PRIO, 32'h0000_0004);
    i_core.set_prio(8'h02);
    i_core.fire(8'h01, 32'h3000_0020);
    rd_chk("pend", fsc_pkg::ADDR_PEND, 32'h0000_0001);
    chk("pending pin", 32'h0000_0001, {31'h0, imprecise_pending});
    i_core.set_prio(8'h05);
    rd_chk("pend", fsc_pkg::ADDR_PEND, 32'h0000_0002);
    chk("activate pin", 32'h0000_0001, {31'h0, imprecise_activate});
    i_core.fire(8'h80, 32'h3000_0024);
    rd_chk("pend", fsc_pkg::ADDR_PEND, 32'h0000_0000);
    chk("activate pin", 32'h0000_0000, {31'h0, imprecise_activate});
    $display("test pending done");
    conclude();
  end
endmodule
